// ---- core/serial_port_pkg.sv ----
// shared constants and carriers for the metering serial register port
package serial_port_pkg;

    // ****************************************
    // command byte layout
    // ****************************************
    localparam int cmd_bits = 8;
    localparam int cmd_dir_bit = 7;
    localparam int addr_bits = 5;
    localparam logic cmd_dir_write = 1'b1;
    localparam logic cmd_dir_read = 1'b0;

    // ****************************************
    // data layout
    // ****************************************
    localparam int max_reg_bytes = 3;
    localparam int data_bits = 8 * max_reg_bytes;
    localparam int bits_per_byte = 8;
    localparam logic [1:0] reg_bytes_reset = 2'h1;

    // ****************************************
    // serial state machine
    // ****************************************
    typedef enum logic [1:0] {
        st_command = 2'b00,
        st_write = 2'b01,
        st_read = 2'b10
    } port_state_t;

    // request to the register file: address and command
    typedef struct packed {
        logic [4:0] addr;
        logic write;
    } reg_cmd_t;

    // one written byte, msb byte first
    typedef struct packed {
        logic [4:0] addr;
        logic [1:0] byte_index;
        logic [7:0] data;
    } write_byte_t;

endpackage

// ---- core/pin_sync.sv ----
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter logic reset_value = 1'b0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;

    always_ff @(posedge clock) begin
        if (reset) begin
            stage1 <= reset_value;
            sync_out <= reset_value;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// ---- core/edge_detect.sv ----
// rising and falling edge detector on a synchronised level
`timescale 1ns/1ps
module edge_detect #(
    parameter logic reset_value = 1'b0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic last;

    always_ff @(posedge clock) begin
        if (reset) begin
            last <= reset_value;
        end else begin
            last <= level;
        end
    end

    assign rise = level & ~last;
    assign fall = ~level & last;
endmodule

// ---- core/metering_serial_register_port.sv ----
// serial register port: command byte, then register data msb byte first
// Notes on behaviour
// - reset or select fall enters command mode
// - command msb 1 writes; low five bits address
// - transfer ends after last register bit
// - finished transfer returns to command mode
// - input sampled on serial clock falling edges
// - output changes on serial clock rising edges
// - timing follows serial clock, not master clock
// - select falling edge resets state machine
// - select rise aborts and floats output
// - write data starts first fall after command
// - aborted partial write byte is discarded
// - up to three bytes, msb first, right-justified
// - read drives first bit at first rise
// - read end floats output at last fall
// - aborted read floats output at select rise
// - whole register captured when read addressed
`timescale 1ns/1ps
module metering_serial_register_port
    import serial_port_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic serial_clock,
    input wire logic serial_in,
    input wire logic chip_select_n,
    output logic serial_out,
    output logic serial_out_en_n,
    output serial_port_pkg::reg_cmd_t reg_cmd,
    output logic reg_cmd_valid,
    input wire logic [1:0] reg_bytes,
    input wire logic [serial_port_pkg::data_bits-1:0] reg_read_data,
    output serial_port_pkg::write_byte_t write_byte,
    output logic write_byte_valid,
    output logic transfer_done
);
    import serial_port_pkg::*;

    // ****************************************
    // pin synchronisers and edges
    // ****************************************
    logic sclk_s;
    logic din_s;
    logic cs_n_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_fall;

    pin_sync #(.reset_value(1'b1)) u_sync_sclk (
        .clock(clock), .reset(reset), .async_in(serial_clock), .sync_out(sclk_s)
    );
    pin_sync #(.reset_value(1'b0)) u_sync_din (
        .clock(clock), .reset(reset), .async_in(serial_in), .sync_out(din_s)
    );
    pin_sync #(.reset_value(1'b1)) u_sync_cs (
        .clock(clock), .reset(reset), .async_in(chip_select_n), .sync_out(cs_n_s)
    );
    edge_detect #(.reset_value(1'b1)) u_edge_sclk (
        .clock(clock), .reset(reset), .level(sclk_s), .rise(sclk_rise), .fall(sclk_fall)
    );
    edge_detect #(.reset_value(1'b1)) u_edge_cs (
        .clock(clock), .reset(reset), .level(cs_n_s), .rise(cs_rise), .fall(cs_fall)
    );

    // shifting only while selected
    logic active;
    logic shift_in;
    logic shift_out;
    assign active = ~cs_n_s;
    assign shift_in = active & sclk_fall;
    assign shift_out = active & sclk_rise;

    // ****************************************
    // state machine and counters
    // ****************************************
    port_state_t state;
    logic [2:0] bit_count;
    logic [1:0] byte_count;
    logic [1:0] total_bytes;
    logic [7:0] in_shift;
    logic [data_bits-1:0] out_shift;
    logic [4:0] cur_addr;
    logic last_bit;
    logic [7:0] next_byte;

    assign last_bit = (bit_count == 3'h7);
    assign next_byte = {in_shift[6:0], din_s};

    always_ff @(posedge clock) begin
        if (reset || cs_fall || cs_rise) begin
            state <= st_command;
        end else if (shift_in && last_bit) begin
            case (state)
                st_command: begin
                    if (next_byte[cmd_dir_bit] == cmd_dir_write) begin
                        state <= st_write;
                    end else begin
                        state <= st_read;
                    end
                end
                st_write, st_read: begin
                    if (byte_count == total_bytes - 2'h1) begin
                        state <= st_command;
                    end
                end
                default: state <= st_command;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset || cs_fall || cs_rise) begin
            bit_count <= 3'h0;
            byte_count <= 2'h0;
        end else if (shift_in) begin
            bit_count <= bit_count + 3'h1;
            if (last_bit) begin
                if (state == st_command || byte_count == total_bytes - 2'h1) begin
                    byte_count <= 2'h0;
                end else begin
                    byte_count <= byte_count + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            in_shift <= 8'h00;
        end else if (shift_in) begin
            in_shift <= next_byte;
        end
    end

    // ****************************************
    // command decode and register capture
    // ****************************************
    logic cmd_done;
    assign cmd_done = (state == st_command) && shift_in && last_bit;

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_cmd <= '0;
            reg_cmd_valid <= 1'b0;
            cur_addr <= 5'h00;
        end else begin
            reg_cmd_valid <= cmd_done;
            if (cmd_done) begin
                reg_cmd.addr <= next_byte[addr_bits-1:0];
                reg_cmd.write <= next_byte[cmd_dir_bit];
                cur_addr <= next_byte[addr_bits-1:0];
            end
        end
    end

    // width is known one cycle after the command byte
    always_ff @(posedge clock) begin
        if (reset) begin
            total_bytes <= reg_bytes_reset;
        end else if (reg_cmd_valid) begin
            total_bytes <= (reg_bytes == 2'h0) ? reg_bytes_reset : reg_bytes;
        end
    end

    // read data aligned so its first byte sits at the top
    logic [data_bits-1:0] aligned;
    always_comb begin
        case (reg_bytes)
            2'h2: aligned = {reg_read_data[15:0], 8'h00};
            2'h3: aligned = reg_read_data;
            default: aligned = {reg_read_data[7:0], 16'h0000};
        endcase
    end

    logic out_loaded;
    always_ff @(posedge clock) begin
        if (reset) begin
            out_shift <= '0;
            out_loaded <= 1'b0;
        end else if (reg_cmd_valid && !reg_cmd.write) begin
            out_shift <= aligned;
            out_loaded <= 1'b1;
        end else if (shift_out && state == st_read) begin
            if (out_loaded) begin
                out_loaded <= 1'b0;
            end else begin
                out_shift <= {out_shift[data_bits-2:0], 1'b0};
            end
        end
    end

    // ****************************************
    // serial output driver
    // ****************************************
    always_ff @(posedge clock) begin
        if (reset || cs_rise) begin
            serial_out <= 1'b0;
            serial_out_en_n <= 1'b1;
        end else if (state == st_read && shift_in && last_bit && byte_count == total_bytes - 2'h1) begin
            serial_out_en_n <= 1'b1;
        end else if (shift_out && state == st_read) begin
            serial_out_en_n <= 1'b0;
            serial_out <= out_loaded ? out_shift[data_bits-1] : out_shift[data_bits-2];
        end
    end

    // ****************************************
    // write bytes and completion
    // ****************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            write_byte <= '0;
            write_byte_valid <= 1'b0;
            transfer_done <= 1'b0;
        end else begin
            write_byte_valid <= (state == st_write) && shift_in && last_bit;
            transfer_done <= (state != st_command) && shift_in && last_bit
                && byte_count == total_bytes - 2'h1;
            if (state == st_write && shift_in && last_bit) begin
                write_byte.addr <= cur_addr;
                write_byte.byte_index <= byte_count;
                write_byte.data <= next_byte;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_select_fall_command;
        @(posedge clock) disable iff (reset) cs_fall |=> state == st_command;
    endproperty
    a_select_fall_command: assert property (p_select_fall_command) else $error("no command mode");

    property p_abort_floats;
        @(posedge clock) disable iff (reset) cs_rise |=> serial_out_en_n;
    endproperty
    a_abort_floats: assert property (p_abort_floats) else $error("output not floated");

    property p_done_returns;
        @(posedge clock) disable iff (reset) transfer_done |-> state == st_command;
    endproperty
    a_done_returns: assert property (p_done_returns) else $error("not back in command");

    property p_write_decode;
        @(posedge clock) disable iff (reset)
            cmd_done && next_byte[cmd_dir_bit] && !cs_rise && !cs_fall |=> state == st_write;
    endproperty
    a_write_decode: assert property (p_write_decode) else $error("write not decoded");

    property p_no_partial_write;
        @(posedge clock) disable iff (reset) write_byte_valid |-> $past(last_bit);
    endproperty
    a_no_partial_write: assert property (p_no_partial_write) else $error("partial byte written");

    property p_read_drives;
        @(posedge clock) disable iff (reset)
            state == st_read && shift_out && !cs_rise |=> !serial_out_en_n;
    endproperty
    a_read_drives: assert property (p_read_drives) else $error("read not driven");

    property p_out_on_rise;
        @(posedge clock) disable iff (reset)
            !shift_out && !cs_rise && !reset |=> $stable(serial_out);
    endproperty
    a_out_on_rise: assert property (p_out_on_rise) else $error("output moved off rise");

    property p_idle_float;
        @(posedge clock) disable iff (reset)
            state == st_command && !shift_out |=> serial_out_en_n == $past(serial_out_en_n) || serial_out_en_n;
    endproperty
    a_idle_float: assert property (p_idle_float) else $error("driven in command");

    // ****************************************
    // shifting and output checks
    // ****************************************
    property p_state_on_fall;
        @(posedge clock) disable iff (reset)
            !shift_in && !cs_fall && !cs_rise |=> $stable(state);
    endproperty
    a_state_on_fall: assert property (p_state_on_fall) else $error("state moved off fall");

    property p_bits_on_fall;
        @(posedge clock) disable iff (reset)
            !shift_in && !cs_fall && !cs_rise |=> $stable(bit_count);
    endproperty
    a_bits_on_fall: assert property (p_bits_on_fall) else $error("bit counted off fall");

    property p_read_end_floats;
        @(posedge clock) disable iff (reset)
            state == st_read && shift_in && last_bit && byte_count == total_bytes - 2'h1 |=> serial_out_en_n;
    endproperty
    a_read_end_floats: assert property (p_read_end_floats) else $error("read end not floated");

    property p_first_bit_msb;
        @(posedge clock) disable iff (reset)
            state == st_read && shift_out && out_loaded
            |=> !serial_out_en_n && serial_out == $past(out_shift[data_bits-1]);
    endproperty
    a_first_bit_msb: assert property (p_first_bit_msb) else $error("first bit not msb");

    property p_capture_whole;
        @(posedge clock) disable iff (reset)
            reg_cmd_valid && !reg_cmd.write |=> out_loaded && out_shift == $past(aligned);
    endproperty
    a_capture_whole: assert property (p_capture_whole) else $error("register not captured");

    property p_partial_dropped;
        @(posedge clock) disable iff (reset) cs_rise |=> !write_byte_valid && !transfer_done;
    endproperty
    a_partial_dropped: assert property (p_partial_dropped) else $error("aborted byte written");

    property p_write_byte_data;
        @(posedge clock) disable iff (reset)
            state == st_write && shift_in && last_bit
            |=> write_byte_valid && write_byte.data == $past(next_byte) && write_byte.addr == $past(cur_addr);
    endproperty
    a_write_byte_data: assert property (p_write_byte_data) else $error("write byte wrong");

    property p_byte_bound;
        @(posedge clock) disable iff (reset) state != st_command |-> byte_count < total_bytes;
    endproperty
    a_byte_bound: assert property (p_byte_bound) else $error("byte count past width");

    property p_cmd_not_driven;
        @(posedge clock) disable iff (reset) reg_cmd_valid |-> serial_out_en_n;
    endproperty
    a_cmd_not_driven: assert property (p_cmd_not_driven) else $error("driven before first rise");

    property p_write_floats;
        @(posedge clock) disable iff (reset) state == st_write |-> serial_out_en_n;
    endproperty
    a_write_floats: assert property (p_write_floats) else $error("driven during write");

    property p_cmd_fields;
        @(posedge clock) disable iff (reset)
            cmd_done |=> reg_cmd_valid && reg_cmd.addr == $past(next_byte[addr_bits-1:0]);
    endproperty
    a_cmd_fields: assert property (p_cmd_fields) else $error("command fields wrong");

endmodule

// ---- sim/serial_host_model.sv ----
// host microcontroller model driving the serial register port
`timescale 1ns/1ps
module serial_host_model (
    input wire logic clock,
    input wire logic serial_out,
    input wire logic serial_out_en_n,
    output logic serial_clock,
    output logic serial_in,
    output logic chip_select_n
);
    logic last = 1'b0;
    logic line;
    // released data line shows the inverse of its last driven value
    always @(posedge clock) begin
        if (serial_out_en_n === 1'b0) last <= serial_out;
    end
    assign line = (serial_out_en_n === 1'b0) ? serial_out : ~last;
    initial begin
        serial_clock = 1'b1;
        serial_in = 1'b0;
        chip_select_n = 1'b1;
    end
    // ****************************************
    // select and bit shifting
    // ****************************************
    // select held low by the callers, raised mid-transfer by the abort tests
    task automatic select(input logic level);
        @(posedge clock);
        chip_select_n <= level;
    endtask
    // data set one clock after rise (inverted at rise), device samples at fall, host reads before fall
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx, output logic drove);
        rx = 8'h00;
        drove = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            serial_in <= tx[7-i];
            repeat (12) @(posedge clock);
            rx = {rx[6:0], line};
            drove = drove & (serial_out_en_n === 1'b0);
            serial_clock <= 1'b0;
            repeat (12) @(posedge clock);
            serial_clock <= 1'b1;
            serial_in <= ~tx[7-i];
        end
    endtask
endmodule

// ---- sim/metering_serial_register_port_test.sv ----
// self-checking bench for the metering serial register port
`timescale 1ns/1ps
`define compare(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
    $display("Error %s expected %h seen %h", name, exp, got); fails++; end end
module metering_serial_register_port_test;
    import serial_port_pkg::*;
    logic clock;
    logic reset = 1'b1;
    logic [1:0] reg_bytes = 2'h0;
    logic [data_bits-1:0] reg_read_data = 24'h000000;
    logic serial_clock, serial_in, chip_select_n, serial_out, serial_out_en_n;
    logic reg_cmd_valid, write_byte_valid, transfer_done, drove;
    logic [7:0] rx;
    reg_cmd_t reg_cmd, last_cmd;
    write_byte_t write_byte;
    write_byte_t wq[$];
    int fails = 0;
    int cmp_count = 0;
    int done_n = 0;
    metering_serial_register_port u_metering_serial_register_port (.clock(clock), .reset(reset),
        .serial_clock(serial_clock), .serial_in(serial_in), .chip_select_n(chip_select_n),
        .serial_out(serial_out), .serial_out_en_n(serial_out_en_n), .reg_cmd(reg_cmd),
        .reg_cmd_valid(reg_cmd_valid), .reg_bytes(reg_bytes), .reg_read_data(reg_read_data),
        .write_byte(write_byte), .write_byte_valid(write_byte_valid), .transfer_done(transfer_done));
    serial_host_model u_serial_host_model (.clock(clock), .serial_out(serial_out),
        .serial_out_en_n(serial_out_en_n), .serial_clock(serial_clock), .serial_in(serial_in),
        .chip_select_n(chip_select_n));
    // ****************************************
    // monitors and helpers
    // ****************************************
    always @(posedge clock) begin
        if (write_byte_valid === 1'b1) wq.push_back(write_byte);
        if (transfer_done === 1'b1) done_n++;
        if (reg_cmd_valid === 1'b1) last_cmd = reg_cmd;
    end
    task automatic clear();
        wq.delete();
        done_n = 0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic send(input logic [7:0] b);
        u_serial_host_model.shift(b, 8, rx, drove);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic write_three();
        logic [7:0] wd [3];
        wd = '{8'h12, 8'h34, 8'h56};
        clear();
        reg_bytes <= 2'h3;
        u_serial_host_model.select(1'b0);
        cyc(12);
        send(8'h86);
        for (int b = 0; b < 3; b++) begin
            cyc(820);
            send(wd[b]);
        end
        cyc(10);
        `compare("write count", 3, wq.size())
        for (int b = 0; b < 3; b++) begin
            `compare("write byte", {5'h06, 2'(b), wd[b]}, wq[b])
        end
        `compare("write done", 1, done_n)
        `compare("write cmd", {5'h06, 1'b1}, last_cmd)
    endtask
    task automatic read_two();
        clear();
        reg_bytes <= 2'h2;
        reg_read_data <= 24'h000abc;
        cyc(820);
        send(8'h0b);
        reg_read_data <= 24'h000555;
        send(8'h00);
        `compare("read msb", 8'h0a, rx)
        `compare("read drive", 1'b1, drove)
        send(8'h00);
        `compare("read lsb", 8'hbc, rx)
        `compare("read drive lsb", 1'b1, drove)
        `compare("read float", 1'b1, serial_out_en_n)
        `compare("read done", 1, done_n)
        `compare("read cmd", {5'h0b, 1'b0}, last_cmd)
    endtask
    task automatic back_to_back();
        clear();
        reg_bytes <= 2'h0;
        send(8'h81);
        send(8'h5a);
        cyc(10);
        `compare("one byte count", 1, wq.size())
        `compare("one byte", {5'h01, 2'h0, 8'h5a}, wq[0])
        `compare("one byte done", 1, done_n)
    endtask
    task automatic abort_write();
        clear();
        reg_bytes <= 2'h1;
        cyc(820);
        send(8'h82);
        u_serial_host_model.shift(8'hff, 4, rx, drove);
        u_serial_host_model.select(1'b1);
        cyc(20);
        `compare("partial count", 0, wq.size())
        `compare("partial done", 0, done_n)
        u_serial_host_model.select(1'b0);
        cyc(12);
        send(8'h83);
        send(8'hc3);
        cyc(10);
        `compare("restart count", 1, wq.size())
        `compare("restart byte", {5'h03, 2'h0, 8'hc3}, wq[0])
    endtask
    task automatic abort_read();
        clear();
        reg_read_data <= 24'h0000f0;
        cyc(820);
        send(8'h04);
        u_serial_host_model.shift(8'h00, 3, rx, drove);
        `compare("abort bits", 3'h7, rx[2:0])
        `compare("abort drive", 1'b1, drove)
        u_serial_host_model.select(1'b1);
        for (int n = 0; n < 8 && serial_out_en_n !== 1'b1; n++) cyc(1);
        `compare("abort float", 1'b1, serial_out_en_n)
        if (serial_out_en_n !== 1'b1) test_done();
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        cyc(10);
        reset <= 1'b0;
        cyc(5);
        `compare("idle float", 1'b1, serial_out_en_n)
        write_three();
        read_two();
        back_to_back();
        abort_write();
        abort_read();
        test_done();
    end
endmodule
